/* core/feature_config_defines.vh */
// Purpose: Constants for the feature configuration loader of a smoke-detector controller.
// Assumes: 10 MHz core clock; all tester pins are asynchronous to it.
// Notes: All timing counts assume the 10 MHz core clock.
// Function
// - Position 18 of the feature word is unimplemented and has no effect.
// - Trip field 17:16 decodes 00 7.5V, 01 7.8V, 10 6.9V, 11 7.2V.
// - Bit 15 high enables end-of-life indication.
// - Bit 14 high enables the gas alarm on the interconnect line.
// - Bit 13 high disables auto alarm locate.
// - Bit 12 high locks horn pattern to interconnected units.
// - Bit 11 high allows silencing the low battery warning.
// - Bit 10 high chirps the horn for alarm memory during button test.
// - Bit 9 high flashes the LED for alarm memory during button test.
// - Timeout field 8:7 decodes 24h, 48h, zero hours, never.
// - Bit 6 high enables alarm memory.
// - Bit 5 selects an 80 second or 9 minute silence timer.
// - Bit 4 high lets high or remote smoke end silence early.
// - Bit 3 high starts silence only during local smoke alarm.
// - Bit 2 high disables silence; low enables it.
// - Bit 1 high gives continuous tone, low temporal tone.
// - Verify modes only after calibration is stored.
// - Twelve steps then data low 1 ms shows standby smoke on verify output.
// - Thirteen steps enter hysteresis verify; data pulse triggers a check.
// - Fourteen steps enter silence verify; data pulse triggers detection.
// - Fifteen steps enter chamber verify; data pulse gives a result.
// - In feature entry one data bit shifts per shift clock, 18 bits.
// - Interconnect pulse of at least 10 ms commits the word.
`ifndef FEATURE_CONFIG_DEFINES_VH
`define FEATURE_CONFIG_DEFINES_VH
`define WORD_W 18
`define CLK_HZ 10000000
`define STORE_PULSE_MS 10
`define STORE_CYCLES ((`STORE_PULSE_MS * `CLK_HZ) / 1000)
`define STANDBY_HOLD_MS 1
`define STANDBY_CYCLES ((`STANDBY_HOLD_MS * `CLK_HZ) / 1000)
`define SILENCE_SHORT_S 80
`define SILENCE_LONG_MIN 9
`define STEP_FEATURE 5'h02
`define STEP_STANDBY 5'h0C
`define STEP_HYST 5'h0D
`define STEP_SILENCE 5'h0E
`define STEP_CHAMBER 5'h0F
`define BIT_TRIP_HI 17
`define BIT_TRIP_LO 16
`define BIT_EOL 15
`define BIT_GAS 14
`define BIT_NOAUTO 13
`define BIT_SYNC 12
`define BIT_LBSIL 11
`define BIT_CHIRP 10
`define BIT_FLASH 9
`define BIT_TO_HI 8
`define BIT_TO_LO 7
`define BIT_AMEM 6
`define BIT_SILTMR 5
`define BIT_SMART 4
`define BIT_ALARMONLY 3
`define BIT_SILDIS_N 2
`define BIT_TONE 1
`define TRIP_7V5 2'h0
`define TRIP_7V8 2'h1
`define TRIP_6V9 2'h2
`define TRIP_7V2 2'h3
`define TO_24H 2'h0
`define TO_48H 2'h1
`define TO_0H 2'h2
`define TO_NEVER 2'h3
`endif

/* core/feature_config_loader.v */
// Purpose: Tester-driven entry of the user feature word and selection of verify modes.
// Assumes: All tester pins are asynchronous; they are synchronised before use.
// Notes: The word is kept LSB-first as shifted; bit n of the word is index n-1 here.
`timescale 1ns/100ps
`include "feature_config_defines.vh"
module feature_config_loader #(
  parameter STORE_CYCLES = `STORE_CYCLES
) (
  input wire clock,
  input wire resetn,
  input wire mode_step_clock,
  input wire data_in,
  input wire shift_clock,
  input wire link_in,
  input wire calib_stored,
  input wire smoke_detect,
  output reg feature_entry_mode,
  output reg standby_verify_mode,
  output reg hysteresis_verify_mode,
  output reg silence_verify_mode,
  output reg chamber_verify_mode,
  output reg verify_result_out,
  output reg store_strobe,
  output reg [`WORD_W-1:0] user_feature_word,
  output reg [1:0] low_batt_trip,
  output reg end_of_life_enable,
  output reg gas_alarm_link_enable,
  output reg auto_locate,
  output reg horn_lockstep_enable,
  output reg low_batt_silence_enable,
  output reg memory_chirp_enable,
  output reg memory_flash_enable,
  output reg [1:0] memory_timeout,
  output reg alarm_memory_enable,
  output reg silence_timer_long,
  output reg smart_silence,
  output reg silence_in_alarm_only,
  output reg silence_enable,
  output reg tone_continuous
);

////////////////////////////////////////////////////////////////////////////////
// Synchronisers and edge detection.

// Every tester pin is asynchronous to the core clock, so each passes two
// flip-flops; a third flop keeps the previous level for edge detection. All
// of them reset low, the idle level of every pin, so no false edge follows
// reset. The analog detection level is free-running and is synchronised too.
localparam PIN_STEP = 0;
localparam PIN_DATA = 1;
localparam PIN_SHIFT = 2;
localparam PIN_LINK = 3;
localparam PIN_COUNT = 4;

wire [PIN_COUNT-1:0] pin_raw = {link_in, shift_clock, data_in, mode_step_clock};
wire [PIN_COUNT-1:0] pin_s;
wire [PIN_COUNT-1:0] pin_d;
genvar gi;

generate
  for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_sync
    reg [1:0] sync_ff;
    reg delay_ff;
    always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        sync_ff <= 2'h0;
        delay_ff <= 1'b0;
      end else begin
        sync_ff <= {sync_ff[0], pin_raw[gi]};
        delay_ff <= sync_ff[1];
      end
    end
    assign pin_s[gi] = sync_ff[1];
    assign pin_d[gi] = delay_ff;
  end
endgenerate

wire step_s = pin_s[PIN_STEP];
wire data_s = pin_s[PIN_DATA];
wire shift_s = pin_s[PIN_SHIFT];
wire link_s = pin_s[PIN_LINK];
wire step_fall = pin_d[PIN_STEP] & ~step_s;
wire shift_rise = shift_s & ~pin_d[PIN_SHIFT];
wire data_rise = data_s & ~pin_d[PIN_DATA];
wire link_fall = pin_d[PIN_LINK] & ~link_s;

reg [1:0] smoke_sync_ff;
wire smoke_s = smoke_sync_ff[1];

always @(posedge clock or negedge resetn) begin
  if (!resetn) begin
    smoke_sync_ff <= 2'h0;
  end else begin
    smoke_sync_ff <= {smoke_sync_ff[0], smoke_detect};
  end
end

////////////////////////////////////////////////////////////////////////////////
// Mode sequencer.

localparam ST_IDLE = 2'h0;
localparam ST_ARMED = 2'h1;
localparam ST_COUNT = 2'h2;
localparam ST_LOCKED = 2'h3;

reg [1:0] state_ff;
reg [1:0] nxt_state;
reg [4:0] step_cnt_ff;
reg [4:0] nxt_step_cnt;

// Counting starts only after the step pin and then the data pin have been
// raised, so stray step glitches in normal operation cannot walk the device
// into a test mode. The step count saturates so that a long burst of pulses
// cannot wrap back into feature entry. After a store the sequencer locks
// until power-on reset, because a stored word may only change by a full
// re-entry after power down.
always @* begin
  nxt_state = state_ff;
  nxt_step_cnt = step_cnt_ff;
  case (state_ff)
    ST_IDLE: begin
      if (step_s & ~data_s) begin
        nxt_state = ST_ARMED;
      end
    end
    ST_ARMED: begin
      if (!step_s) begin
        nxt_state = ST_IDLE;
      end else if (data_s) begin
        nxt_state = ST_COUNT;
      end
    end
    ST_COUNT: begin
      if (step_fall && step_cnt_ff != 5'h1F) begin
        nxt_step_cnt = step_cnt_ff + 5'h01;
      end
      if (store_strobe) begin
        nxt_state = ST_LOCKED;
      end
    end
    ST_LOCKED: begin
      nxt_state = ST_LOCKED;
    end
    default: begin
      nxt_state = ST_IDLE;
    end
  endcase
end

// One decode of the step count, shared by the four verify modes; each mode
// also needs a finished entry sequence and stored calibration.
function mode_hit;
  input [4:0] count;
  input [4:0] target;
  input ok;
  begin
    mode_hit = ok && (count == target);
  end
endfunction

wire in_entry = (state_ff == ST_COUNT) && (step_cnt_ff == `STEP_FEATURE);
wire verify_ok = (state_ff == ST_COUNT) && calib_stored;

always @(posedge clock or negedge resetn) begin
  if (!resetn) begin
    state_ff <= ST_IDLE;
    step_cnt_ff <= 5'h00;
    feature_entry_mode <= 1'b0;
    standby_verify_mode <= 1'b0;
    hysteresis_verify_mode <= 1'b0;
    silence_verify_mode <= 1'b0;
    chamber_verify_mode <= 1'b0;
  end else begin
    state_ff <= nxt_state;
    step_cnt_ff <= nxt_step_cnt;
    feature_entry_mode <= in_entry;
    standby_verify_mode <= mode_hit(step_cnt_ff, `STEP_STANDBY, verify_ok);
    hysteresis_verify_mode <= mode_hit(step_cnt_ff, `STEP_HYST, verify_ok);
    silence_verify_mode <= mode_hit(step_cnt_ff, `STEP_SILENCE, verify_ok);
    chamber_verify_mode <= mode_hit(step_cnt_ff, `STEP_CHAMBER, verify_ok);
  end
end

////////////////////////////////////////////////////////////////////////////////
// Shift register, store pulse timing and commit.

// Shift edges beyond the eighteenth are dropped rather than pushing the
// first bits out. The interconnect must stay high for the whole store time;
// its counter stops at the limit, so a very long pulse is still one store.
reg [`WORD_W-1:0] shift_ff;
reg [4:0] bit_cnt_ff;
reg [23:0] link_cnt_ff;
reg link_long_ff;

always @(posedge clock or negedge resetn) begin
  if (!resetn) begin
    shift_ff <= {`WORD_W{1'b0}};
    bit_cnt_ff <= 5'h00;
    link_cnt_ff <= 24'h000000;
    link_long_ff <= 1'b0;
    store_strobe <= 1'b0;
    user_feature_word <= {`WORD_W{1'b0}};
  end else begin
    store_strobe <= 1'b0;
    // Bits arrive LSB first; a new bit enters at the top and moves down.
    if (in_entry && shift_rise && bit_cnt_ff != `WORD_W) begin
      shift_ff <= {data_s, shift_ff[`WORD_W-1:1]};
      bit_cnt_ff <= bit_cnt_ff + 5'h01;
    end
    if (link_s && in_entry) begin
      if (link_cnt_ff != STORE_CYCLES[23:0]) begin
        link_cnt_ff <= link_cnt_ff + 24'h000001;
      end else begin
        link_long_ff <= 1'b1;
      end
    end else if (!link_s) begin
      link_cnt_ff <= 24'h000000;
      link_long_ff <= 1'b0;
    end
    // A short or out-of-mode pulse on the interconnect is not a store.
    if (in_entry && link_fall && link_long_ff) begin
      store_strobe <= 1'b1;
      user_feature_word <= shift_ff;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Verify result.

// Standby check: the data pin must stay low for the whole hold time before
// the detection level is shown, so a short dip shows nothing. The other
// three checks latch the detection level on each rising data edge and hold
// it until the next edge or until the mode is left.
reg [15:0] hold_cnt_ff;
wire any_pulse_mode = hysteresis_verify_mode | silence_verify_mode | chamber_verify_mode;

always @(posedge clock or negedge resetn) begin
  if (!resetn) begin
    hold_cnt_ff <= 16'h0000;
    verify_result_out <= 1'b0;
  end else begin
    if (standby_verify_mode && !data_s) begin
      if (hold_cnt_ff != `STANDBY_CYCLES) begin
        hold_cnt_ff <= hold_cnt_ff + 16'h0001;
      end
    end else begin
      hold_cnt_ff <= 16'h0000;
    end
    if (standby_verify_mode) begin
      verify_result_out <= (hold_cnt_ff == `STANDBY_CYCLES) && smoke_s;
    end else if (any_pulse_mode) begin
      if (data_rise) begin
        verify_result_out <= smoke_s;
      end
    end else begin
      verify_result_out <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Feature decode. Word index is bit position minus one; position 18 is ignored.
// Each decode is a flop fed from the stored word, so it follows a store one
// cycle later; before any store it shows the decode of an all-zero word.

always @(posedge clock or negedge resetn) begin
  if (!resetn) begin
    low_batt_trip <= `TRIP_7V5;
    end_of_life_enable <= 1'b0;
    gas_alarm_link_enable <= 1'b0;
    auto_locate <= 1'b1;
    horn_lockstep_enable <= 1'b0;
    low_batt_silence_enable <= 1'b0;
    memory_chirp_enable <= 1'b0;
    memory_flash_enable <= 1'b0;
    memory_timeout <= `TO_24H;
    alarm_memory_enable <= 1'b0;
    silence_timer_long <= 1'b1;
    smart_silence <= 1'b0;
    silence_in_alarm_only <= 1'b0;
    silence_enable <= 1'b1;
    tone_continuous <= 1'b0;
  end else begin
    low_batt_trip <= {user_feature_word[`BIT_TRIP_HI-1],
                      user_feature_word[`BIT_TRIP_LO-1]};
    end_of_life_enable <= user_feature_word[`BIT_EOL-1];
    gas_alarm_link_enable <= user_feature_word[`BIT_GAS-1];
    auto_locate <= ~user_feature_word[`BIT_NOAUTO-1];
    horn_lockstep_enable <= user_feature_word[`BIT_SYNC-1];
    low_batt_silence_enable <= user_feature_word[`BIT_LBSIL-1];
    memory_chirp_enable <= user_feature_word[`BIT_CHIRP-1];
    memory_flash_enable <= user_feature_word[`BIT_FLASH-1];
    memory_timeout <= {user_feature_word[`BIT_TO_HI-1],
                       user_feature_word[`BIT_TO_LO-1]};
    alarm_memory_enable <= user_feature_word[`BIT_AMEM-1];
    silence_timer_long <= ~user_feature_word[`BIT_SILTMR-1];
    smart_silence <= user_feature_word[`BIT_SMART-1];
    silence_in_alarm_only <= user_feature_word[`BIT_ALARMONLY-1];
    silence_enable <= ~user_feature_word[`BIT_SILDIS_N-1];
    tone_continuous <= user_feature_word[`BIT_TONE-1];
  end
end

endmodule

/* bench/feature_config_loader_checker.sv */
// Purpose: Port assertions for the feature configuration loader.
// Assumes: calib_stored stays steady while a verify mode stands.
// Notes: Decodes are compared with the word one cycle earlier.
`timescale 1ns/100ps
`include "feature_config_defines.vh"
module feature_config_loader_checker (
  input wire clock,
  input wire resetn,
  input wire calib_stored,
  input wire feature_entry_mode,
  input wire standby_verify_mode,
  input wire hysteresis_verify_mode,
  input wire silence_verify_mode,
  input wire chamber_verify_mode,
  input wire store_strobe,
  input wire [`WORD_W-1:0] user_feature_word,
  input wire [1:0] low_batt_trip,
  input wire [1:0] memory_timeout,
  input wire auto_locate,
  input wire silence_timer_long,
  input wire silence_enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire [3:0] verify_any = {standby_verify_mode, hysteresis_verify_mode,
    silence_verify_mode, chamber_verify_mode};
  reg entry_seen_ff;
  // Sticky, because a store may legally come long after entry was seen.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) entry_seen_ff <= 1'b0;
    else if (feature_entry_mode) entry_seen_ff <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_store_single: assert property (store_strobe |=> !store_strobe)
    else $error("store strobe longer than one cycle");
  a_store_entry: assert property (store_strobe |-> entry_seen_ff)
    else $error("store without feature entry");
  a_verify_calib: assert property (|verify_any |-> calib_stored)
    else $error("verify mode without calibration");
  a_modes_exclusive: assert property ($onehot0({feature_entry_mode, verify_any}))
    else $error("two modes at once");
  a_word_change: assert property ($changed(user_feature_word) |->
    store_strobe || $past(store_strobe))
    else $error("word changed without store");
  a_trip_decode: assert property (low_batt_trip == $past(user_feature_word[16:15]))
    else $error("trip decode wrong");
  a_timeout_decode: assert property (memory_timeout == $past(user_feature_word[7:6]))
    else $error("timeout decode wrong");
  a_locate_decode: assert property (auto_locate == !$past(user_feature_word[12]))
    else $error("locate decode wrong");
  a_timer_decode: assert property (silence_timer_long == !$past(user_feature_word[4]))
    else $error("timer decode wrong");
  a_silence_decode: assert property (silence_enable == !$past(user_feature_word[1]))
    else $error("silence decode wrong");
  c_store: cover property (store_strobe);
  c_standby: cover property (standby_verify_mode);
  c_chamber: cover property (chamber_verify_mode);
endmodule
bind feature_config_loader feature_config_loader_checker chk_u (.clock(clock),
  .resetn(resetn), .calib_stored(calib_stored), .feature_entry_mode(feature_entry_mode),
  .standby_verify_mode(standby_verify_mode), .hysteresis_verify_mode(hysteresis_verify_mode),
  .silence_verify_mode(silence_verify_mode), .chamber_verify_mode(chamber_verify_mode),
  .store_strobe(store_strobe), .user_feature_word(user_feature_word),
  .low_batt_trip(low_batt_trip), .memory_timeout(memory_timeout), .auto_locate(auto_locate),
  .silence_timer_long(silence_timer_long), .silence_enable(silence_enable));

/* bench/feature_tester_model.sv */
// Purpose: Factory tester driving step, data, shift and link pins.
// Assumes: Callers enter each task just after a rising clock edge.
// Notes: The 800 ns shift clock runs only inside a frame and rests low.
`timescale 1ns/100ps
module feature_tester_model (
  input wire clock,
  output reg mode_step_clock,
  output reg data_in,
  output reg shift_clock,
  output reg link_in
);
  initial {mode_step_clock, data_in, shift_clock, link_in} = 4'h0;
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic rest;
    {mode_step_clock, data_in, shift_clock, link_in} <= 4'h0;
  endtask
  task automatic enter(input int steps);
    mode_step_clock <= 1'b1;
    tick(8);
    data_in <= 1'b1;
    tick(8);
    repeat (steps) begin
      mode_step_clock <= 1'b0;
      tick(4);
      mode_step_clock <= 1'b1;
      tick(4);
    end
  endtask
  task automatic shift_word(input logic [17:0] w);
    for (int i = 0; i < 18; i++) begin
      data_in <= w[i];
      tick(4);
      shift_clock <= 1'b1;
      tick(4);
      shift_clock <= 1'b0;
    end
  endtask
  task automatic store(input int n);
    link_in <= 1'b1;
    tick(n);
    link_in <= 1'b0;
    tick(1);
  endtask
  task automatic hold_data(input logic v, input int n);
    data_in <= v;
    tick(n);
  endtask
endmodule

/* bench/feature_config_loader_tb.sv */
// Purpose: Self-checking bench for the feature configuration loader.
// Assumes: A shortened store pulse of 50 cycles stands in for 10 ms.
// Notes: Each store needs a fresh reset because the word locks.
`timescale 1ns/100ps
module feature_config_loader_tb;
  localparam int STORE_N = 50;
  reg clock, resetn, calib_stored, smoke_detect;
  wire mode_step_clock, data_in, shift_clock, link_in, store_strobe, verify_result_out;
  wire feature_entry_mode, standby_verify_mode, hysteresis_verify_mode;
  wire silence_verify_mode, chamber_verify_mode;
  wire [17:0] user_feature_word;
  wire [1:0] low_batt_trip, memory_timeout;
  wire end_of_life_enable, gas_alarm_link_enable, auto_locate, horn_lockstep_enable;
  wire low_batt_silence_enable, memory_chirp_enable, memory_flash_enable;
  wire alarm_memory_enable, silence_timer_long, smart_silence, silence_in_alarm_only;
  wire silence_enable, tone_continuous;
  int num_errors = 0;
  int checked = 0;
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  feature_tester_model model_u (.clock, .mode_step_clock, .data_in, .shift_clock, .link_in);
  feature_config_loader #(.STORE_CYCLES(STORE_N)) dut_u (.clock, .resetn, .mode_step_clock,
    .data_in, .shift_clock, .link_in, .calib_stored, .smoke_detect, .feature_entry_mode,
    .standby_verify_mode, .hysteresis_verify_mode, .silence_verify_mode, .chamber_verify_mode,
    .verify_result_out, .store_strobe, .user_feature_word, .low_batt_trip,
    .end_of_life_enable, .gas_alarm_link_enable, .auto_locate, .horn_lockstep_enable,
    .low_batt_silence_enable, .memory_chirp_enable, .memory_flash_enable, .memory_timeout,
    .alarm_memory_enable, .silence_timer_long, .smart_silence, .silence_in_alarm_only,
    .silence_enable, .tone_continuous);
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [17:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic do_reset(input logic cal);
    resetn <= 1'b0;
    calib_stored <= cal;
    model_u.rest();
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
  endtask
  task automatic send(input logic [17:0] w, input int high_n, input int expect_n);
    int c;
    c = 0;
    model_u.shift_word(w);
    model_u.store(high_n);
    repeat (20) begin
      @(negedge clock);
      if (store_strobe === 1'b1) c++;
    end
    @(posedge clock);
    check("store strobes", c, expect_n);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_outside;
    do_reset(1'b0);
    check("reset decodes", {auto_locate, silence_timer_long, silence_enable,
      low_batt_trip, memory_timeout}, 7'h70);
    send(18'h3FFFF, STORE_N + 20, 0);
    check("word idle", user_feature_word[16:0], 17'h0);
    $display("test outside entry done");
  endtask
  task automatic t_store(input logic [17:0] w);
    do_reset(1'b0);
    model_u.enter(2);
    repeat (8) @(posedge clock);
    check("entry mode", feature_entry_mode, 1'b1);
    send(w, STORE_N - 20, 0);
    send(w, STORE_N + 20, 1);
    check("word", user_feature_word[16:0], w[16:0]);
    check("trip", low_batt_trip, w[16:15]);
    check("timeout", memory_timeout, w[7:6]);
    check("flags a", {end_of_life_enable, gas_alarm_link_enable, auto_locate,
      horn_lockstep_enable}, {w[14], w[13], ~w[12], w[11]});
    check("flags b", {low_batt_silence_enable, memory_chirp_enable, memory_flash_enable,
      alarm_memory_enable}, {w[10], w[9], w[8], w[5]});
    check("flags c", {silence_timer_long, smart_silence, silence_in_alarm_only,
      silence_enable, tone_continuous}, {~w[4], w[3], w[2], ~w[1], w[0]});
    send(~w, STORE_N + 20, 0);
    check("word kept", user_feature_word[16:0], w[16:0]);
    $display("test store %h done", w);
  endtask
  task automatic t_verify;
    do_reset(1'b0);
    model_u.enter(12);
    repeat (8) @(posedge clock);
    check("gated", standby_verify_mode, 1'b0);
    for (int n = 12; n < 16; n++) begin
      smoke_detect <= (n != 14);
      do_reset(1'b1);
      model_u.enter(n);
      repeat (8) @(posedge clock);
      check("mode", {standby_verify_mode, hysteresis_verify_mode, silence_verify_mode,
        chamber_verify_mode}, 4'h8 >> (n - 12));
      if (n == 12) begin
        model_u.hold_data(1'b0, 9990);
        check("early", verify_result_out, 1'b0);
        model_u.hold_data(1'b0, 60);
      end else begin
        model_u.hold_data(1'b0, 20);
        model_u.hold_data(1'b1, 10);
        check("first", verify_result_out, n != 14);
        smoke_detect <= (n == 14);
        model_u.hold_data(1'b0, 20);
        check("held", verify_result_out, n != 14);
        model_u.hold_data(1'b1, 10);
      end
      check("result", verify_result_out, n == 12 || n == 14);
    end
    $display("test verify modes done");
  endtask
  initial begin
    resetn = 1'b0;
    calib_stored = 1'b0;
    smoke_detect = 1'b0;
    @(posedge clock);
    t_outside();
    t_store(18'h37A24);
    t_store(18'h085DB);
    t_store(18'h3FA64);
    t_store(18'h0059B);
    t_verify();
    give_verdict();
  end
endmodule
